/* File: src/msp_pkg.sv */
/*
 * msp_pkg: shared constants and carriers for the memory select and paging
 * block. Assumes a 40 MHz system clock and an 8-bit host bus.
 */
package msp_pkg;

    // clock and flash recovery timing
    localparam int CLK_HZ = 40_000_000;
    localparam int RECOVER_US = 25;
    localparam int RECOVER_CYCLES = (RECOVER_US * (CLK_HZ / 1_000_000) > 0)
        ? RECOVER_US * (CLK_HZ / 1_000_000) : 1;
    localparam int RECOVER_CW = 11;

    // control register space offsets
    localparam logic [7:0] OFS_PAGE_EXTENSION = 8'hE0;
    localparam logic [7:0] OFS_MEMORY_SPACE_MAP = 8'hE2;
    localparam logic [7:0] OFS_PRIMARY_LOCK = 8'hE4;
    localparam logic [7:0] OFS_SECONDARY_LOCK = 8'hE5;

    // reset values
    localparam logic [7:0] PAGE_RESET = 8'h00;
    localparam logic [7:0] MAP_RESET = 8'h0C;
    localparam logic [7:0] DATA_RESET = 8'h00;

    // memory space map field positions
    localparam int MAP_SRAM_CODE = 0;
    localparam int MAP_SECONDARY_CODE = 1;
    localparam int MAP_PRIMARY_CODE = 2;
    localparam int MAP_SECONDARY_DATA = 3;
    localparam int MAP_PRIMARY_DATA = 4;
    localparam int MAP_PERIPHERAL_IO = 7;

    // secondary lock status field positions
    localparam int SEC_LOCK_SECURITY = 7;

    // width of the shared logic array input bus
    localparam int ARRAY_INPUTS = 73;

    // host bus pins as sampled
    typedef struct packed {
        logic [15:0] addr;
        logic [7:0] data;
        logic program_fetch_strobe_n;
        logic control_input_one_n;
        logic write_strobe_n;
        logic control_register_space;
    } msp_bus_t;

    // external port pins as sampled
    typedef struct packed {
        logic host_reset_n;
        logic power_down;
        logic [7:0] port_a;
        logic [7:0] port_b;
        logic [7:0] port_c;
        logic [2:0] port_d;
    } msp_pins_t;

    // flash recovery sequence
    typedef enum logic [1:0] {
        ST_READ = 2'b00,
        ST_ABORT = 2'b01,
        ST_RECOVER = 2'b11
    } msp_state_t;

endpackage : msp_pkg

/* File: src/msp_paging.sv */
/*
 * msp_paging: memory select priority, space map strobe gating, page
 * register, sector lock status and reset abort of flash activity.
 * Assumes host pins are asynchronous to sys_clk and held for at least
 * three clock periods; the sector select terms come from the address
 * decode array on the same pins and are sampled with them.
 */
// Function
// - reset pulse aborts flash, returns read mode
// - busy flash back in read within 25us
// - primary lock status bit per sector
// - secondary lock status in bits three-zero
// - bit seven shows security lock, others zero
// - SRAM responds only while select high
// - secondary sector beats overlapping primary sector
// - SRAM or I/O beats any flash sector
// - memories reachable by fetch, read, both
// - bits two and four combine primary
// - space map initial value, always writable
// - eight bit page register at E0h
// - page bits feed the address decoder
// - unused page bits reach general logic
// - logic arrays get 73-signal input bus
// - lock status bits are read only
// - writes to locked sectors are ignored
`timescale 1ns/1ps

module msp_paging
    import msp_pkg::*;
#(
    parameter logic [7:0] MAP_INIT = MAP_RESET,
    parameter int RECOVER_LIMIT = RECOVER_CYCLES
)
(
    // clock and reset
    input wire logic sys_clk,
    input wire logic reset_n,
    // host bus pins
    input wire msp_bus_t host_bus,
    output logic [7:0] data_out,
    output logic data_oe_n,
    // external pins for the logic arrays
    input wire msp_pins_t ext_pins,
    // decode terms, sampled like the bus
    input wire logic sram_select_term,
    input wire logic [7:0] primary_sector_selects,
    input wire logic [3:0] secondary_sector_selects,
    input wire logic [1:0] peripheral_selects,
    // same-clock logic feeding the arrays
    input wire logic [7:0] output_cell_ab_feedback,
    input wire logic [7:0] output_cell_bc_feedback,
    input wire logic ready_busy,
    // lock configuration
    input wire logic [7:0] primary_lock,
    input wire logic [3:0] secondary_lock,
    input wire logic security_set,
    // flash sequencer
    input wire logic flash_busy,
    input wire logic [7:0] primary_write_req,
    input wire logic [3:0] secondary_write_req,
    output logic [7:0] primary_write_grant,
    output logic [3:0] secondary_write_grant,
    output logic flash_abort,
    output logic flash_read_mode,
    // memory enables
    output logic sram_enable,
    output logic io_enable,
    output logic [1:0] peripheral_enable,
    output logic [7:0] primary_enable,
    output logic [3:0] secondary_enable,
    // page and logic array outputs
    output logic [7:0] page_bits,
    output logic [ARRAY_INPUTS-1:0] array_inputs
);

    // read mux over the control register space
    function automatic logic [7:0] reg_read(
        input logic [7:0] ofs,
        input logic [7:0] page,
        input logic [7:0] map,
        input logic [7:0] plock,
        input logic [7:0] slock
    );
        logic [7:0] val;
        val = DATA_RESET;
        case (ofs)
            OFS_PAGE_EXTENSION: val = page;
            OFS_MEMORY_SPACE_MAP: val = map;
            OFS_PRIMARY_LOCK: val = plock;
            OFS_SECONDARY_LOCK: val = slock;
            default: val = DATA_RESET;
        endcase
        return val;
    endfunction : reg_read

    msp_bus_t bus_meta;
    msp_bus_t bus_sync;
    msp_pins_t pins_meta;
    msp_pins_t pins_sync;
    logic [2:0] sel_meta_misc;
    logic [2:0] sel_sync_misc;
    logic [11:0] sel_meta_flash;
    logic [11:0] sel_sync_flash;
    logic wr_seen;
    logic host_reset_seen;
    logic [7:0] page_extension;
    logic [7:0] memory_space_map;
    logic [7:0] primary_sector_lock_status;
    logic [7:0] secondary_sector_lock_status;
    msp_state_t state;
    msp_state_t next_state;
    logic [RECOVER_CW-1:0] recover_count;
    logic reg_write;
    logic reg_read_active;
    logic fetch;
    logic data_read;
    logic write;
    logic high_level;
    logic secondary_hit;
    logic primary_code_access;
    logic primary_data_access;
    logic secondary_code_access;
    logic secondary_data_access;
    logic peripheral_io_enable;
    logic primary_path;
    logic secondary_path;

    // two-flop synchronisers for every host pin
    always_ff @(posedge sys_clk)
    begin
        if (!reset_n)
        begin
            bus_meta <= '1;
            bus_sync <= '1;
            sel_meta_misc <= '0;
            sel_sync_misc <= '0;
            sel_meta_flash <= '0;
            sel_sync_flash <= '0;
        end
        else
        begin
            bus_meta <= host_bus;
            bus_sync <= bus_meta;
            sel_meta_misc <= {sram_select_term, peripheral_selects};
            sel_sync_misc <= sel_meta_misc;
            sel_meta_flash <= {secondary_sector_selects,
                primary_sector_selects};
            sel_sync_flash <= sel_meta_flash;
        end
    end

    // two-flop synchronisers for port and reset pins
    always_ff @(posedge sys_clk)
    begin
        if (!reset_n)
        begin
            pins_meta <= '0;
            pins_sync <= '0;
            pins_meta.host_reset_n <= 1'b1;
            pins_sync.host_reset_n <= 1'b1;
        end
        else
        begin
            pins_meta <= ext_pins;
            pins_sync <= pins_meta;
        end
    end

    // edge memory for write strobe and host reset
    always_ff @(posedge sys_clk)
    begin
        if (!reset_n)
        begin
            wr_seen <= 1'b0;
            host_reset_seen <= 1'b0;
        end
        else
        begin
            wr_seen <= ~bus_sync.write_strobe_n;
            host_reset_seen <= ~pins_sync.host_reset_n;
        end
    end

    // decoded strobes
    assign fetch = ~bus_sync.program_fetch_strobe_n;
    assign data_read = ~bus_sync.control_input_one_n;
    assign write = ~bus_sync.write_strobe_n;
    assign reg_write = write & ~wr_seen & bus_sync.control_register_space;
    assign reg_read_active = data_read & bus_sync.control_register_space;

    always_ff @(posedge sys_clk)
    begin
        if (!reset_n)
            page_extension <= PAGE_RESET;
        else if (reg_write && bus_sync.addr[7:0] == OFS_PAGE_EXTENSION)
            page_extension <= bus_sync.data;
    end

    always_ff @(posedge sys_clk)
    begin
        if (!reset_n)
            memory_space_map <= MAP_INIT;
        else if (reg_write && bus_sync.addr[7:0] == OFS_MEMORY_SPACE_MAP)
            memory_space_map <= bus_sync.data;
    end

    always_ff @(posedge sys_clk)
    begin
        if (!reset_n)
        begin
            primary_sector_lock_status <= DATA_RESET;
            secondary_sector_lock_status <= DATA_RESET;
        end
        else
        begin
            primary_sector_lock_status <= primary_lock;
            secondary_sector_lock_status <= DATA_RESET;
            secondary_sector_lock_status[3:0] <= secondary_lock;
            secondary_sector_lock_status[SEC_LOCK_SECURITY] <= security_set;
        end
    end

    // register read back and data pin drive
    always_ff @(posedge sys_clk)
    begin
        if (!reset_n)
            data_out <= DATA_RESET;
        else if (reg_read_active)
            data_out <= reg_read(bus_sync.addr[7:0], page_extension,
                memory_space_map, primary_sector_lock_status,
                secondary_sector_lock_status);
    end

    assign data_oe_n = ~(reg_read_active & reset_n);

    // space map fields
    assign secondary_code_access = memory_space_map[MAP_SECONDARY_CODE];
    assign primary_code_access = memory_space_map[MAP_PRIMARY_CODE];
    assign secondary_data_access = memory_space_map[MAP_SECONDARY_DATA];
    assign primary_data_access = memory_space_map[MAP_PRIMARY_DATA];
    assign peripheral_io_enable = memory_space_map[MAP_PERIPHERAL_IO];

    assign primary_path = (fetch & primary_code_access)
        | (data_read & primary_data_access) | write;
    assign secondary_path = (fetch & secondary_code_access)
        | (data_read & secondary_data_access) | write;

    assign high_level = sel_sync_misc[2] | bus_sync.control_register_space
        | (peripheral_io_enable & (|sel_sync_misc[1:0]));
    assign secondary_hit = |sel_sync_flash[11:8];

    // registered memory enables
    always_ff @(posedge sys_clk)
    begin
        if (!reset_n)
        begin
            sram_enable <= 1'b0;
            io_enable <= 1'b0;
            peripheral_enable <= '0;
            primary_enable <= '0;
            secondary_enable <= '0;
        end
        else
        begin
            sram_enable <= sel_sync_misc[2]
                & ((fetch & memory_space_map[MAP_SRAM_CODE])
                | data_read | write);
            io_enable <= bus_sync.control_register_space
                & (data_read | write);
            peripheral_enable <= sel_sync_misc[1:0]
                & {2{peripheral_io_enable & (data_read | write)}};
            secondary_enable <= sel_sync_flash[11:8]
                & {4{~high_level & secondary_path}};
            primary_enable <= sel_sync_flash[7:0]
                & {8{~high_level & ~secondary_hit & primary_path}};
        end
    end

    // locked sectors refuse program and erase
    always_ff @(posedge sys_clk)
    begin
        if (!reset_n)
        begin
            primary_write_grant <= '0;
            secondary_write_grant <= '0;
        end
        else
        begin
            primary_write_grant <= primary_write_req & ~primary_lock;
            secondary_write_grant <= secondary_write_req & ~secondary_lock;
        end
    end

    always_comb
    begin
        next_state = state;
        case (state)
            ST_READ:
                if (~pins_sync.host_reset_n & ~host_reset_seen)
                    next_state = ST_ABORT;
            ST_ABORT:
                next_state = flash_busy ? ST_RECOVER : ST_READ;
            ST_RECOVER:
                if (!flash_busy
                    || recover_count >= RECOVER_CW'(RECOVER_LIMIT - 2))
                    next_state = ST_READ;
            default:
                next_state = ST_READ;
        endcase
    end

    // recovery state register
    always_ff @(posedge sys_clk)
    begin
        if (!reset_n)
            state <= ST_READ;
        else
            state <= next_state;
    end

    // recovery cycle counter
    always_ff @(posedge sys_clk)
    begin
        if (!reset_n)
            recover_count <= '0;
        else if (state == ST_RECOVER)
            recover_count <= recover_count + RECOVER_CW'(1);
        else
            recover_count <= '0;
    end

    assign flash_abort = (state == ST_ABORT);
    assign flash_read_mode = (state == ST_READ);

    assign page_bits = page_extension;

    // all page bits reach general logic
    always_ff @(posedge sys_clk)
    begin
        if (!reset_n)
            array_inputs <= '0;
        else
            array_inputs <= {bus_sync.addr,
                ~bus_sync.program_fetch_strobe_n,
                ~bus_sync.control_input_one_n,
                ~bus_sync.write_strobe_n,
                ~pins_sync.host_reset_n,
                pins_sync.power_down,
                pins_sync.port_a,
                pins_sync.port_b,
                pins_sync.port_c,
                pins_sync.port_d,
                page_extension,
                output_cell_ab_feedback,
                output_cell_bc_feedback,
                ready_busy};
    end

endmodule : msp_paging

/* File: bench/msp_paging_chk.sv */
/*
 * msp_paging_chk: port assertions for the memory select and paging block.
 * Assumes it is bound to msp_paging, with one clock and synchronous reset.
 */
`timescale 1ns/1ps
module msp_paging_chk
    import msp_pkg::*;
#(
    parameter int RECOVER_LIMIT = 8
)
(
    // clock and reset
    input wire logic sys_clk,
    input wire logic reset_n,
    // watched ports
    input wire logic sram_select_term,
    input wire logic [7:0] primary_lock,
    input wire logic [3:0] secondary_lock,
    input wire logic flash_abort,
    input wire logic flash_read_mode,
    input wire logic [7:0] primary_write_grant,
    input wire logic [3:0] secondary_write_grant,
    input wire logic sram_enable,
    input wire logic io_enable,
    input wire logic [7:0] primary_enable,
    input wire logic [3:0] secondary_enable,
    input wire logic [7:0] page_bits,
    input wire msp_pins_t ext_pins,
    input wire logic [ARRAY_INPUTS-1:0] array_inputs
);
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!reset_n);
    logic [15:0] low_cnt;
    // cycles spent out of read mode
    always_ff @(posedge sys_clk)
    begin
        if (!reset_n || flash_read_mode)
            low_cnt <= 16'h0000;
        else
            low_cnt <= low_cnt + 16'h0001;
    end
    property p_abort_pulse;
        flash_abort |=> !flash_abort;
    endproperty
    a_abort_pulse: assert property (p_abort_pulse)
        else $error("abort pulse longer than one cycle");
    property p_abort_mode;
        flash_abort |-> !flash_read_mode;
    endproperty
    a_abort_mode: assert property (p_abort_mode)
        else $error("read mode kept during abort");
    property p_recover;
        int'(low_cnt) <= RECOVER_LIMIT + 2;
    endproperty
    a_recover: assert property (p_recover)
        else $error("flash out of read mode too long");
    property p_sram_cause;
        sram_enable |-> $past(sram_select_term, 3)
            || $past(sram_select_term, 4);
    endproperty
    a_sram_cause: assert property (p_sram_cause)
        else $error("sram enabled without its select");
    property p_sec_first;
        (|secondary_enable) |-> primary_enable == 8'h00;
    endproperty
    a_sec_first: assert property (p_sec_first)
        else $error("primary enabled beside secondary");
    property p_local_first;
        sram_enable || io_enable
            |-> {primary_enable, secondary_enable} == 12'h000;
    endproperty
    a_local_first: assert property (p_local_first)
        else $error("flash enabled beside sram or io");
    property p_lock_pri;
        (primary_write_grant & $past(primary_lock)) == 8'h00;
    endproperty
    a_lock_pri: assert property (p_lock_pri)
        else $error("grant to locked primary sector");
    property p_lock_sec;
        (secondary_write_grant & $past(secondary_lock)) == 4'h0;
    endproperty
    a_lock_sec: assert property (p_lock_sec)
        else $error("grant to locked secondary sector");
    property p_page_feed;
        $past(reset_n) |-> array_inputs[24:17] == $past(page_bits);
    endproperty
    a_page_feed: assert property (p_page_feed)
        else $error("page bits missing from array inputs");
    // reset and port pins feed arrays after two sync stages
    property p_pins_feed;
        $past(reset_n, 3) |-> array_inputs[53:25]
            == {~$past(ext_pins[28], 3), $past(ext_pins[27:0], 3)};
    endproperty
    a_pins_feed: assert property (p_pins_feed)
        else $error("port pins missing from array inputs");
    // main scenarios reached
    c_abort: cover property (flash_abort);
    c_sec: cover property (|secondary_enable);
    c_long: cover property (int'(low_cnt) == RECOVER_LIMIT);
endmodule : msp_paging_chk

bind msp_paging msp_paging_chk #(.RECOVER_LIMIT(RECOVER_LIMIT)) u_chk (
    .sys_clk(sys_clk), .reset_n(reset_n),
    .sram_select_term(sram_select_term), .primary_lock(primary_lock),
    .secondary_lock(secondary_lock), .flash_abort(flash_abort),
    .flash_read_mode(flash_read_mode),
    .primary_write_grant(primary_write_grant),
    .secondary_write_grant(secondary_write_grant),
    .sram_enable(sram_enable), .io_enable(io_enable),
    .primary_enable(primary_enable), .secondary_enable(secondary_enable),
    .page_bits(page_bits), .ext_pins(ext_pins),
    .array_inputs(array_inputs));

/* File: bench/msp_host.sv */
/*
 * msp_host: host bus model driving the block's bus pins.
 * Assumes the block samples the pins on sys_clk rising edges.
 */
`timescale 1ns/1ps
module msp_host
    import msp_pkg::*;
(
    // clock
    input wire logic sys_clk,
    // bus pins
    output msp_bus_t bus,
    input wire logic [7:0] data_out,
    input wire logic data_oe_n
);
    // data pin enable seen when read data was taken
    logic oe_seen = 1'b1;
    // idle: strobes high, no select
    initial
    begin
        bus = {16'h0000, 8'h00, 4'hE};
    end
    // control space cycle, strobe held 5 cycles
    task automatic cyc(input logic [7:0] ofs, input logic wr,
        input logic [7:0] val, output logic [7:0] got);
        @(negedge sys_clk);
        bus.addr = {8'h00, ofs};
        bus.data = val;
        bus.control_register_space = 1'b1;
        repeat (3) @(negedge sys_clk);
        bus.write_strobe_n = !wr;
        bus.control_input_one_n = wr;
        repeat (5) @(negedge sys_clk);
        got = data_out;
        oe_seen = data_oe_n;
        bus.write_strobe_n = 1'b1;
        bus.control_input_one_n = 1'b1;
        repeat (4) @(negedge sys_clk);
        // released data lines change pattern
        bus.data = ~val;
        bus.control_register_space = 1'b0;
    endtask : cyc
    // memory strobe: 0 fetch, 1 read, 2 write
    task automatic strobe(input logic [1:0] kind, input logic on);
        @(negedge sys_clk);
        bus.program_fetch_strobe_n = !(on && kind == 2'd0);
        bus.control_input_one_n = !(on && kind == 2'd1);
        bus.write_strobe_n = !(on && kind == 2'd2);
    endtask : strobe
endmodule : msp_host

/* File: bench/msp_paging_tb_top.sv */
/*
 * msp_paging_tb_top: self-checking bench for msp_paging.
 * Assumes msp_host drives the bus pins and the checker is bound.
 */
`timescale 1ns/1ps
module msp_paging_tb_top
    import msp_pkg::*;
;
    localparam int LIM = 8;
    logic sys_clk = 1'b0;
    logic reset_n = 1'b0;
    msp_bus_t host_bus;
    msp_pins_t ext_pins;
    logic hr_n = 1'b1;
    logic [27:0] noise = 28'h0000000;
    logic sr = 1'b0;
    logic [1:0] pp = 2'b00;
    logic [1:0] ppe;
    logic ioe;
    logic oe_n;
    logic [7:0] x;
    logic [7:0] ps = 8'h00;
    logic [3:0] ss = 4'h0;
    logic [16:0] fb = 17'h00000;
    logic [7:0] pl = 8'h00;
    logic [3:0] sl = 4'h0;
    logic sec = 1'b0;
    logic busy = 1'b0;
    logic [7:0] pr = 8'h00;
    logic [3:0] sq = 4'h0;
    logic [7:0] dout;
    logic [7:0] pg;
    logic [7:0] pe;
    logic [3:0] se;
    logic [7:0] pwg;
    logic [3:0] swg;
    logic ab;
    logic rm;
    logic sre;
    logic [7:0] v;
    int n_errors = 0;
    int num_checks = 0;
    int cycles = 0;

    always #12.5 sys_clk = ~sys_clk;

    msp_host u_host (.sys_clk(sys_clk), .bus(host_bus), .data_out(dout),
        .data_oe_n(oe_n));

    msp_paging #(.RECOVER_LIMIT(LIM)) u_dut (
        .sys_clk(sys_clk), .reset_n(reset_n), .host_bus(host_bus),
        .data_out(dout), .data_oe_n(oe_n), .ext_pins(ext_pins),
        .sram_select_term(sr), .primary_sector_selects(ps),
        .secondary_sector_selects(ss), .peripheral_selects(pp),
        .output_cell_ab_feedback(fb[16:9]), .output_cell_bc_feedback(fb[8:1]),
        .ready_busy(fb[0]), .primary_lock(pl), .secondary_lock(sl),
        .security_set(sec), .flash_busy(busy), .primary_write_req(pr),
        .secondary_write_req(sq), .primary_write_grant(pwg),
        .secondary_write_grant(swg), .flash_abort(ab), .flash_read_mode(rm),
        .sram_enable(sre), .io_enable(ioe), .peripheral_enable(ppe),
        .primary_enable(pe), .secondary_enable(se), .page_bits(pg),
        .array_inputs());

    // random noise on array-only pins
    always @(negedge sys_clk)
    begin
        fb <= 17'($urandom);
        noise <= 28'($urandom);
    end

    // host reset pin above the noisy power-down and port pins
    assign ext_pins = {hr_n, noise};

    // hang guard
    always @(posedge sys_clk)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            n_errors++;
            summarize();
        end
    end

    task automatic check(input string what, input logic [31:0] seen,
        input logic [31:0] exp);
        num_checks++;
        if (seen !== exp)
        begin
            n_errors++;
            $display("[FAIL] %s expected %0h seen %0h", what, exp, seen);
        end
    endtask : check

    task automatic summarize;
        $display("checks %0d mismatches %0d", num_checks, n_errors);
        if (n_errors == 0 && num_checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : summarize

    // expected {peripheral, sram, secondary, primary} enables
    function automatic logic [14:0] exp_en(input logic [7:0] m,
        input logic [1:0] k, input logic s, input logic [1:0] io,
        input logic [7:0] p, input logic [3:0] q);
        logic f;
        logic r;
        logic w;
        logic hi;
        f = (k == 2'd0);
        r = (k == 2'd1);
        w = (k == 2'd2);
        hi = s | (m[7] & (|io));
        return {io & {2{m[7] & (r | w)}}, s & (f & m[0] | r | w),
            hi ? 4'h0 : q & {4{f & m[1] | r & m[3] | w}},
            (hi | (|q)) ? 8'h00 : p & {8{f & m[2] | r & m[4] | w}}};
    endfunction : exp_en

    task automatic mem_case(input logic [7:0] m, input logic [1:0] k);
        logic [7:0] y;
        int lv;
        u_host.cyc(OFS_MEMORY_SPACE_MAP, 1'b1, m, y);
        u_host.cyc(OFS_MEMORY_SPACE_MAP, 1'b0, 8'h00, y);
        check("map read", y, m);
        lv = $urandom_range(3);
        // one top-level select at most, one-hot primary sector, secondary one-hot or none
        sr <= (lv == 1);
        pp <= (lv == 2) ? 2'b01 : (lv == 3) ? 2'b10 : 2'b00;
        {ps, ss} <= {8'h01 << $urandom_range(7),
            4'($urandom_range(1) << $urandom_range(3))};
        u_host.strobe(k, 1'b1);
        repeat (6) @(negedge sys_clk);
        check("enables", {ppe, sre, se, pe},
            exp_en(m, k, sr, pp, ps, ss));
        check("io enable", ioe, 1'b0);
        u_host.strobe(k, 1'b0);
        {sr, pp, ps, ss} <= 15'h0000;
        repeat (4) @(negedge sys_clk);
    endtask : mem_case

    task automatic abort_case(input logic b);
        int pulses = 0;
        logic low = 1'b0;
        busy <= b;
        hr_n <= 1'b0;
        repeat (LIM + 12)
        begin
            @(negedge sys_clk);
            if (ab === 1'b1)
                pulses++;
            low = low | !rm;
        end
        check("abort pulses", pulses, 1);
        check("read mode left", low, 1'b1);
        check("read mode back", rm, 1'b1);
        hr_n <= 1'b1;
        busy <= 1'b0;
        repeat (4) @(negedge sys_clk);
        $display("abort case busy=%0d done", b);
    endtask : abort_case

    initial
    begin
        void'($urandom(32'h398A5C1C));
        repeat (16) @(negedge sys_clk);
        reset_n <= 1'b1;
        u_host.cyc(OFS_MEMORY_SPACE_MAP, 1'b0, 8'h00, v);
        check("map reset", v, MAP_RESET);
        for (int i = 0; i < 5; i++)
        begin
            v = (i == 4) ? 8'hFF : 8'($urandom);
            u_host.cyc(OFS_PAGE_EXTENSION, 1'b1, v, x);
            check("page pins", pg, v);
            check("oe on write", u_host.oe_seen, 1'b1);
            u_host.cyc(OFS_PAGE_EXTENSION, 1'b0, 8'h00, x);
            check("page read", x, v);
            check("oe on read", u_host.oe_seen, 1'b0);
            {pl, sl, sec} = 13'($urandom);
            u_host.cyc(OFS_PRIMARY_LOCK, 1'b1, ~pl, x);
            u_host.cyc(OFS_PRIMARY_LOCK, 1'b0, 8'h00, x);
            check("primary lock", x, pl);
            u_host.cyc(OFS_SECONDARY_LOCK, 1'b0, 8'h00, x);
            check("secondary lock", x, {sec, 3'b000, sl});
            {pr, sq} <= 12'($urandom);
            repeat (2) @(negedge sys_clk);
            check("grants", {pwg, swg}, {pr & ~pl, sq & ~sl});
        end
        u_host.cyc(8'hE7, 1'b0, 8'h00, v);
        check("unmapped", v, 8'h00);
        $display("register tests done");
        for (int k = 0; k < 3; k++)
        begin
            mem_case(8'h0C, 2'(k));
            mem_case(8'h14, 2'(k));
        end
        for (int i = 0; i < 40; i++)
            mem_case({1'($urandom), 2'b00, 5'($urandom)},
                2'($urandom_range(2)));
        $display("memory select tests done");
        abort_case(1'b1);
        abort_case(1'b0);
        summarize();
    end
endmodule : msp_paging_tb_top
